// *** rtl/sdram_cmd_pkg.sv ***
// Overview of operation
// (RQ1) Burst order select bit picks sequential or interleaved beat ordering.
// (RQ2) Sequential beats increment from start and wrap inside the aligned block.
// (RQ3) Interleaved beat k uses starting low column bits XOR k.
// (RQ4) Upper column bits pick the aligned block; low bits pick the start.
// (RQ5) Full-page burst spans the whole row, sequential order only.
// (RQ6) Full-page start uses all column bits and wraps within the row.
// (RQ7) Burst length one accesses exactly the given column; order bit ignored.
// (RQ8) Read latency is programmable to two or three clocks.
// (RQ9) Read at edge n, latency m: drive from n+m-1, valid by n+m.
// (RQ10) Controller uses latency two only at clock rates its grade allows.
// (RQ11) Controller programs both operating mode bits to zero.
// (RQ12) Single write select set: reads burst, writes touch one location only.
// (RQ13) Controller should load zeros into the three top configuration bits.
// (RQ14) Chip select high blocks new commands; running operations carry on.
// (RQ15) Row strobe low alone decodes ACTIVE: opens row in the given bank.
// (RQ16) Column strobe low alone: read burst, or write burst with write enable.
// (RQ17) A10 on read or write enables auto precharge for that access only.
// (RQ18) PRECHARGE closes one bank or all by A10; terminate stops the burst.
// (RQ19) Refresh command: auto refresh if clock enable high, else self refresh.
// (RQ20) All strobes low loads the configuration register from A0 to A11.
// (RQ21) Controller keeps clock enable high for every command except self refresh.
// (RQ22) Byte mask blocks write data same cycle, read outputs two clocks later.
// (RQ23) Configuration fields: length, order, latency, mode, single write, reserved.
// (RQ24) Lengths 1, 2, 4, 8 for both orders; full page sequential only.
// (RQ25) Controller loads configuration only with all banks idle, then waits.
// (RQ26) Length codes 0,1,2,3,7; latency codes 2,3; other codes reserved.
`default_nettype none
package sdram_cmd_pkg;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int DQ_W = 16;
  localparam int MASK_W = 2;
  localparam int BANK_W = 2;
  localparam int BANKS = 4;
  localparam int LOAD_W = 12;
  localparam int AUTO_PRE_BIT = 10;

  localparam logic [2:0] LEN_1 = 3'h0;
  localparam logic [2:0] LEN_2 = 3'h1;
  localparam logic [2:0] LEN_4 = 3'h2;
  localparam logic [2:0] LEN_8 = 3'h3;
  localparam logic [2:0] LEN_FULL = 3'h7;
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;

  localparam logic [COL_W-1:0] SPAN_1 = 10'h000;
  localparam logic [COL_W-1:0] SPAN_2 = 10'h001;
  localparam logic [COL_W-1:0] SPAN_4 = 10'h003;
  localparam logic [COL_W-1:0] SPAN_8 = 10'h007;
  localparam logic [COL_W-1:0] SPAN_FULL = 10'h3FF;

  typedef struct packed {
    logic reserved_cfg_bit_c;
    logic reserved_cfg_bit_b;
    logic reserved_cfg_bit_a;
    logic single_write_select_bit;
    logic op_mode_high_bit;
    logic op_mode_low_bit;
    logic [2:0] read_latency_setting;
    logic burst_order_select_bit;
    logic [2:0] burst_length_setting;
  } cfg_t;

  localparam cfg_t CFG_RESET = 13'h0020;

  typedef struct packed {
    logic cs_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_enable_n;
    logic clock_enable;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] addr;
    logic [MASK_W-1:0] mask;
    logic [DQ_W-1:0] dq;
  } pins_t;

  localparam pins_t PINS_IDLE = '{cs_n: 1'h1, default: '0};

  typedef struct packed {
    logic valid;
    logic write;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [DQ_W-1:0] data;
    logic [MASK_W-1:0] byte_en;
  } array_req_t;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_ACTIVE = 3'b001,
    CMD_READ = 3'b010,
    CMD_WRITE = 3'b011,
    CMD_TERM = 3'b100,
    CMD_PRE = 3'b101,
    CMD_REFRESH = 3'b110,
    CMD_LOAD = 3'b111
  } cmd_t;
endpackage
`default_nettype wire

// *** rtl/sdram_command_decode.sv ***
`default_nettype none
module sdram_command_decode (
  input wire logic clock,
  input wire logic reset,
  input wire sdram_cmd_pkg::pins_t pins,
  input wire logic [sdram_cmd_pkg::DQ_W-1:0] read_data,
  output var sdram_cmd_pkg::array_req_t array_req,
  output logic [sdram_cmd_pkg::DQ_W-1:0] dq_out,
  output logic [sdram_cmd_pkg::DQ_W-1:0] dq_oe,
  output logic [sdram_cmd_pkg::BANKS-1:0] bank_open,
  output logic refresh_pulse,
  output logic self_refresh
);
  localparam int CW = sdram_cmd_pkg::COL_W;

  sdram_cmd_pkg::pins_t pin_meta;
  sdram_cmd_pkg::pins_t pin_s;
  sdram_cmd_pkg::cfg_t operating_configuration;
  sdram_cmd_pkg::cmd_t cmd;
  logic sel;
  logic is_rw;
  logic stop;
  logic [CW-1:0] len_span;
  logic [CW-1:0] new_span;
  logic interleave;
  logic full_page;
  logic lat3;
  logic burst_on;
  logic burst_wr;
  logic burst_ap;
  logic burst_intl;
  logic [sdram_cmd_pkg::BANK_W-1:0] burst_bank;
  logic [CW-1:0] burst_start;
  logic [CW-1:0] burst_span;
  logic [CW-1:0] beat;
  logic burst_last;
  logic ap_done;
  logic [sdram_cmd_pkg::ROW_W-1:0] open_row [sdram_cmd_pkg::BANKS];
  logic dv1;
  logic dv2;
  logic dv3;
  logic oe_base;
  logic [sdram_cmd_pkg::DQ_W-1:0] data_d1;
  logic [sdram_cmd_pkg::DQ_W-1:0] data_d2;
  logic [sdram_cmd_pkg::MASK_W-1:0] mask_p0;
  logic [sdram_cmd_pkg::MASK_W-1:0] mask_p1;

  // pins come from the controller's clock tree; two stages first
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pin_meta <= sdram_cmd_pkg::PINS_IDLE;
      pin_s <= sdram_cmd_pkg::PINS_IDLE;
    end
    else
    begin
      pin_meta <= pins;
      pin_s <= pin_meta;
    end
  end

  // no command while deselected or parked in self refresh
  assign sel = !pin_s.cs_n && !self_refresh; // RQ14

  always_comb
  begin
    cmd = sdram_cmd_pkg::CMD_NONE;
    if (sel)
    begin
      unique case ({pin_s.row_strobe_n, pin_s.col_strobe_n,
                    pin_s.write_enable_n})
        3'h7: cmd = sdram_cmd_pkg::CMD_NONE;
        3'h3: cmd = sdram_cmd_pkg::CMD_ACTIVE; // RQ15
        3'h5: cmd = sdram_cmd_pkg::CMD_READ; // RQ16
        3'h4: cmd = sdram_cmd_pkg::CMD_WRITE; // RQ16
        3'h6: cmd = sdram_cmd_pkg::CMD_TERM; // RQ18
        3'h2: cmd = sdram_cmd_pkg::CMD_PRE; // RQ18
        3'h1: cmd = sdram_cmd_pkg::CMD_REFRESH; // RQ19
        3'h0: cmd = sdram_cmd_pkg::CMD_LOAD; // RQ20
      endcase
    end
  end

  assign is_rw = (cmd == sdram_cmd_pkg::CMD_READ) ||
                 (cmd == sdram_cmd_pkg::CMD_WRITE);
  assign stop = (cmd == sdram_cmd_pkg::CMD_TERM);

  // A12 is not part of the op-code and is stored as zero
  always_ff @(posedge clock)
  begin
    if (reset)
      operating_configuration <= sdram_cmd_pkg::CFG_RESET;
    else if (cmd == sdram_cmd_pkg::CMD_LOAD)
      operating_configuration <= {1'h0,
        pin_s.addr[sdram_cmd_pkg::LOAD_W-1:0]}; // RQ20 RQ23
  end

  // reserved length codes fall back to a single access
  always_comb
  begin
    case (operating_configuration.burst_length_setting)
      sdram_cmd_pkg::LEN_1: len_span = sdram_cmd_pkg::SPAN_1; // RQ7
      sdram_cmd_pkg::LEN_2: len_span = sdram_cmd_pkg::SPAN_2; // RQ26
      sdram_cmd_pkg::LEN_4: len_span = sdram_cmd_pkg::SPAN_4; // RQ24
      sdram_cmd_pkg::LEN_8: len_span = sdram_cmd_pkg::SPAN_8; // RQ4
      sdram_cmd_pkg::LEN_FULL: len_span = sdram_cmd_pkg::SPAN_FULL; // RQ5
      default: len_span = sdram_cmd_pkg::SPAN_1; // RQ26
    endcase
  end

  assign full_page = operating_configuration.burst_length_setting ==
                     sdram_cmd_pkg::LEN_FULL;
  assign interleave = operating_configuration.burst_order_select_bit &&
                      !full_page && (len_span != '0); // RQ1 RQ5 RQ7
  // reserved latency codes behave as three clocks
  assign lat3 = operating_configuration.read_latency_setting !=
                sdram_cmd_pkg::LAT_2; // RQ8 RQ26
  assign new_span = (cmd == sdram_cmd_pkg::CMD_WRITE &&
    operating_configuration.single_write_select_bit) ?
    sdram_cmd_pkg::SPAN_1 : len_span; // RQ12

  function automatic logic [CW-1:0] col_at(
    input logic [CW-1:0] start,
    input logic [CW-1:0] k,
    input logic [CW-1:0] span,
    input logic intl
  );
    logic [CW-1:0] low;
    low = intl ? (start ^ k) : CW'(start + k); // RQ2 RQ3
    return (start & ~span) | (low & span); // RQ4 RQ6
  endfunction

  assign burst_last = (beat == burst_span) &&
                      (burst_span != sdram_cmd_pkg::SPAN_FULL); // RQ6
  assign ap_done = (burst_on && !stop && !is_rw && burst_last &&
                    burst_ap) ||
                   (is_rw && (new_span == '0) && !full_page &&
                    pin_s.addr[sdram_cmd_pkg::AUTO_PRE_BIT]); // RQ17

  // burst sequencer: beat 0 goes out with the command itself
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      burst_on <= 1'h0;
      burst_wr <= 1'h0;
      burst_ap <= 1'h0;
      burst_intl <= 1'h0;
      burst_bank <= '0;
      burst_start <= '0;
      burst_span <= '0;
      beat <= '0;
    end
    else if (is_rw)
    begin
      burst_on <= new_span != '0;
      burst_wr <= cmd == sdram_cmd_pkg::CMD_WRITE;
      // auto precharge never applies to full page
      burst_ap <= pin_s.addr[sdram_cmd_pkg::AUTO_PRE_BIT] &&
                  !full_page; // RQ17
      burst_intl <= interleave; // RQ1
      burst_bank <= pin_s.bank;
      burst_start <= pin_s.addr[CW-1:0];
      burst_span <= new_span;
      beat <= CW'(1);
    end
    else if (stop)
      burst_on <= 1'h0; // RQ18
    else if (burst_on)
    begin
      beat <= CW'(beat + CW'(1));
      if (burst_last)
        burst_on <= 1'h0;
    end
  end

  // array port; write data and byte enables sampled with the beat
  always_ff @(posedge clock)
  begin
    if (reset)
      array_req <= '0;
    else if (is_rw)
    begin
      array_req.valid <= 1'h1;
      array_req.write <= cmd == sdram_cmd_pkg::CMD_WRITE; // RQ16
      array_req.bank <= pin_s.bank;
      array_req.row <= open_row[pin_s.bank];
      array_req.col <= pin_s.addr[CW-1:0]; // RQ7 RQ6
      array_req.data <= pin_s.dq;
      array_req.byte_en <= ~pin_s.mask; // RQ22
    end
    else if (burst_on && !stop)
    begin
      array_req.valid <= 1'h1;
      array_req.write <= burst_wr;
      array_req.bank <= burst_bank;
      array_req.row <= open_row[burst_bank];
      array_req.col <= col_at(burst_start, beat, burst_span,
                              burst_intl); // RQ2 RQ3
      array_req.data <= pin_s.dq;
      array_req.byte_en <= ~pin_s.mask; // RQ22
    end
    else
      array_req.valid <= 1'h0;
  end

  always_ff @(posedge clock)
  begin
    if (cmd == sdram_cmd_pkg::CMD_ACTIVE)
      open_row[pin_s.bank] <= pin_s.addr; // RQ15
  end

  // bank state: auto precharge, then explicit precharge, then activate
  always_ff @(posedge clock)
  begin
    if (reset)
      bank_open <= '0;
    else
    begin
      if (ap_done)
        bank_open[is_rw ? pin_s.bank : burst_bank] <= 1'h0; // RQ17
      if (cmd == sdram_cmd_pkg::CMD_PRE)
      begin
        if (pin_s.addr[sdram_cmd_pkg::AUTO_PRE_BIT])
          bank_open <= '0; // RQ18
        else
          bank_open[pin_s.bank] <= 1'h0; // RQ18
      end
      if (cmd == sdram_cmd_pkg::CMD_ACTIVE)
        bank_open[pin_s.bank] <= 1'h1; // RQ15
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      refresh_pulse <= 1'h0;
      self_refresh <= 1'h0;
    end
    else
    begin
      refresh_pulse <= (cmd == sdram_cmd_pkg::CMD_REFRESH) &&
                       pin_s.clock_enable; // RQ19
      if ((cmd == sdram_cmd_pkg::CMD_REFRESH) && !pin_s.clock_enable)
        self_refresh <= 1'h1; // RQ19
      else if (self_refresh && pin_s.clock_enable)
        self_refresh <= 1'h0;
    end
  end

  // read return: data one stage after the array, then latency stages
  assign dv1 = array_req.valid && !array_req.write;
  assign oe_base = lat3 ? (dv2 || dv3) : (dv1 || dv2); // RQ9

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      dv2 <= 1'h0;
      dv3 <= 1'h0;
      data_d1 <= '0;
      data_d2 <= '0;
      dq_out <= '0;
      mask_p0 <= '0;
      mask_p1 <= '0;
    end
    else
    begin
      dv2 <= dv1;
      dv3 <= dv2;
      data_d1 <= read_data;
      data_d2 <= data_d1;
      dq_out <= lat3 ? data_d2 : data_d1; // RQ8 RQ9
      mask_p0 <= pin_s.mask;
      mask_p1 <= mask_p0;
    end
  end

  for (genvar b = 0; b < sdram_cmd_pkg::MASK_W; b++)
  begin : g_lane
    always_ff @(posedge clock)
    begin
      if (reset)
        dq_oe[b*8 +: 8] <= '0;
      else
        dq_oe[b*8 +: 8] <= {8{oe_base && !mask_p1[b]}}; // RQ22
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_deselect_holds_cfg: // RQ14
  assert property (pin_s.cs_n |=> $stable(operating_configuration))
    else $error("configuration changed while deselected");

  a_load_takes_addr: // RQ20
  assert property (cmd == sdram_cmd_pkg::CMD_LOAD |=>
    operating_configuration == {1'h0, $past(pin_s.addr[11:0])})
    else $error("configuration load mismatch");

  a_active_opens_bank: // RQ15
  assert property (cmd == sdram_cmd_pkg::CMD_ACTIVE |=>
    bank_open[$past(pin_s.bank)])
    else $error("activated bank not open");

  a_beat0_column: // RQ16
  assert property (is_rw |=> array_req.valid &&
    array_req.col == $past(pin_s.addr[9:0]) &&
    array_req.write == $past(cmd == sdram_cmd_pkg::CMD_WRITE))
    else $error("first beat wrong");

  a_interleave_order: // RQ3
  assert property ((cmd == sdram_cmd_pkg::CMD_READ && interleave &&
    len_span == sdram_cmd_pkg::SPAN_4 && pin_s.addr[1:0] == 2'h1)
    ##1 (!is_rw && !stop)[*3] |->
    array_req.col[1:0] == 2'h3 && $past(array_req.col[1:0]) == 2'h0 &&
    $past(array_req.col[1:0], 2) == 2'h1)
    else $error("interleaved order wrong");

  a_sequential_wrap: // RQ2
  assert property ((cmd == sdram_cmd_pkg::CMD_READ && !interleave &&
    len_span == sdram_cmd_pkg::SPAN_8 && pin_s.addr[2:0] == 3'h5)
    ##1 (!is_rw && !stop)[*4] |->
    array_req.col[2:0] == 3'h0 && $past(array_req.col[2:0]) == 3'h7 &&
    array_req.col[9:3] == $past(array_req.col[9:3], 2))
    else $error("sequential wrap wrong");

  a_read_latency_3: // RQ9
  assert property (cmd == sdram_cmd_pkg::CMD_READ && lat3 &&
    pin_s.mask == 2'h0 |-> ##3 dq_oe == 16'hFFFF)
    else $error("outputs not driven at latency");

  a_mask_blocks_read: // RQ22
  assert property (dq_oe[0] |-> !$past(pin_s.mask[0], 3))
    else $error("masked byte driven");

  a_precharge_all: // RQ18
  assert property (cmd == sdram_cmd_pkg::CMD_PRE &&
    pin_s.addr[10] |=> bank_open == '0)
    else $error("precharge all left a bank open");

  a_self_refresh_entry: // RQ19
  assert property (cmd == sdram_cmd_pkg::CMD_REFRESH &&
    !pin_s.clock_enable |=> self_refresh && !refresh_pulse)
    else $error("self refresh not entered");

  a_single_write: // RQ12
  assert property ((cmd == sdram_cmd_pkg::CMD_WRITE &&
    operating_configuration.single_write_select_bit) ##1 !is_rw
    |=> !array_req.valid)
    else $error("write burst under single write");

  c_read_lat3: cover property (cmd == sdram_cmd_pkg::CMD_READ && lat3
    ##3 dq_oe != '0);
  c_intl_write: cover property (burst_on && burst_intl && burst_wr);
  c_self_refresh: cover property ($rose(self_refresh));
  c_page_wrap: cover property (array_req.valid &&
    array_req.col == 10'h3FF ##1 array_req.valid && array_req.col == '0);
endmodule // sdram_command_decode
`default_nettype wire

// *** tb/sdram_ctrl_model.sv ***
`default_nettype none
module sdram_ctrl_model (
  input wire logic clock,
  output var sdram_cmd_pkg::pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cke_level = 1'h1;
  logic [1:0] mask_level = 2'h0;

  initial pins = sdram_cmd_pkg::PINS_IDLE;

  // command on the first cycle, write data on every cycle
  task automatic drive(input logic [3:0] strobe, input logic [1:0] bank,
    input logic [12:0] addr, input logic [15:0] data, input int cycles);
    for (int k = 0; k < cycles; k++)
    begin
      @(negedge clock);
      pins.cs_n = (k == 0) ? strobe[3] : 1'h0;
      pins.row_strobe_n = (k == 0) ? strobe[2] : 1'h1;
      pins.col_strobe_n = (k == 0) ? strobe[1] : 1'h1;
      pins.write_enable_n = (k == 0) ? strobe[0] : 1'h1;
      pins.clock_enable = cke_level;
      pins.bank = bank;
      pins.addr = addr;
      pins.mask = mask_level;
      pins.dq = data + 16'(k);
    end
  endtask

  // deselected: bus content is stale, so it keeps changing
  task automatic idle(input int cycles);
    repeat (cycles)
    begin
      @(negedge clock);
      pins.cs_n = 1'h1;
      pins.clock_enable = cke_level;
      pins.mask = mask_level;
      pins.dq = ~pins.dq;
      pins.addr = ~pins.addr;
    end
  endtask

  // caller precharges all banks first; settle time follows
  task automatic load_cfg(input sdram_cmd_pkg::cfg_t cfg);
    cfg.op_mode_low_bit = 1'h0;
    cfg.op_mode_high_bit = 1'h0;
    cfg.reserved_cfg_bit_a = 1'h0;
    cfg.reserved_cfg_bit_b = 1'h0;
    cfg.reserved_cfg_bit_c = 1'h0;
    drive(4'h0, 2'h0, 13'(cfg), 16'h0000, 1);
    idle(3);
  endtask
endmodule // sdram_ctrl_model
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] RD = 4'h5;
  localparam logic [3:0] WR = 4'h4;
  localparam logic [3:0] ACT = 4'h3;
  localparam logic [3:0] PRE = 4'h2;
  localparam logic [3:0] TERM = 4'h6;
  localparam logic [3:0] REF = 4'h1;
  typedef struct {
    int t;
    logic [15:0] d;
    logic [15:0] oe;
  } due_t;
  logic clock;
  logic reset;
  sdram_cmd_pkg::pins_t pins;
  logic [15:0] read_data;
  sdram_cmd_pkg::array_req_t array_req;
  logic [15:0] dq_out;
  logic [15:0] dq_oe;
  logic [3:0] bank_open;
  logic refresh_pulse;
  logic self_refresh;
  sdram_cmd_pkg::array_req_t exp_q[$];
  due_t due_q[$];
  sdram_cmd_pkg::array_req_t g;
  sdram_cmd_pkg::array_req_t e;
  sdram_cmd_pkg::cfg_t cfg;
  due_t d;
  logic [12:0] rows[4];
  logic [31:0] seed = 32'h00000032;
  logic [31:0] r;
  logic [15:0] oe_exp = 16'hFFFF;
  int lat = 2;
  int len;
  int cyc = 0;
  int refreshes = 0;
  int failures = 0;
  int num_checks = 0;

  sdram_ctrl_model i_ctrl (.clock(clock), .pins(pins));
  sdram_command_decode i_dut (
    .clock(clock),
    .reset(reset),
    .pins(pins),
    .read_data(read_data),
    .array_req(array_req),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .bank_open(bank_open),
    .refresh_pulse(refresh_pulse),
    .self_refresh(self_refresh)
  );

  // 20 MHz allows latency two
  initial
  begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  // array content is a function of the column
  always @(negedge clock) read_data <= {6'h15, array_req.col};

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check_req(input sdram_cmd_pkg::array_req_t got,
    input sdram_cmd_pkg::array_req_t exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // beats are compared as they appear, read data lat cycles later
  always @(negedge clock)
  begin
    cyc++;
    if (refresh_pulse === 1'h1)
      refreshes++;
    if (due_q.size() != 0 && due_q[0].t == cyc)
    begin
      d = due_q.pop_front();
      check_word(dq_oe, d.oe);
      check_word(dq_out & d.oe, d.d & d.oe);
    end
    if (!reset && array_req.valid !== 1'h0)
    begin
      g = array_req;
      e = (exp_q.size() != 0) ? exp_q.pop_front() : '0;
      g.data = g.write ? g.data : '0;
      g.byte_en = g.write ? g.byte_en : '0;
      check_req(g, e);
      if (e.valid && !e.write)
        due_q.push_back('{cyc + lat, {6'h15, e.col}, oe_exp});
    end
  end

  task automatic settle();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || due_q.size() != 0) && n < 80)
    begin
      i_ctrl.idle(1);
      n++;
    end
    if (n == 80)
    begin
      failures++;
      $display("[ERR] %0t left %h exp %h", $time, exp_q.size(), 0);
      print_verdict();
    end
    i_ctrl.idle(3);
    check_word(dq_oe, 16'h0000);
  endtask

  task automatic activate(input logic [1:0] bank, input logic [12:0] row);
    rows[bank] = row;
    i_ctrl.drive(ACT, bank, row, 16'(rnd()), 1);
    i_ctrl.idle(3);
    check_word({12'h000, bank_open} & (16'h0001 << bank),
      16'h0001 << bank);
  endtask

  // stop above zero: full page read cut by terminate after stop beats
  task automatic access(input logic wr, input logic [1:0] bank,
    input logic [9:0] col, input logic ap, input int blen, input logic intl,
    input int stop);
    logic [15:0] base;
    logic [9:0] span;
    sdram_cmd_pkg::array_req_t n;
    base = 16'(rnd());
    span = 10'(blen - 1);
    for (int k = 0; k < ((stop != 0) ? stop : blen); k++)
    begin
      n = '0;
      n.valid = 1'h1;
      n.write = wr;
      n.bank = bank;
      n.row = rows[bank];
      n.col = (col & ~span) |
        ((intl ? col ^ 10'(k) : col + 10'(k)) & span);
      n.data = wr ? base + 16'(k) : '0;
      n.byte_en = wr ? ~i_ctrl.mask_level : '0;
      exp_q.push_back(n);
    end
    if (stop != 0)
    begin
      i_ctrl.drive(RD, bank, {2'h0, ap, col}, base, 2);
      i_ctrl.drive(4'hD, bank, 13'h0000, base, stop - 2);
      i_ctrl.drive(TERM, bank, 13'h0000, base, 1);
    end
    else
      i_ctrl.drive(wr ? WR : RD, bank, {2'h0, ap, col}, base,
        wr ? blen : 1);
    settle();
  endtask

  initial
  begin
    reset = 1'h1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    reset = 1'h0;
    check_word({12'h000, bank_open}, 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      cfg = '0;
      cfg.burst_length_setting = 3'(i % 4);
      cfg.burst_order_select_bit = i[2];
      cfg.read_latency_setting = i[3] ? sdram_cmd_pkg::LAT_3 :
        sdram_cmd_pkg::LAT_2;
      cfg.single_write_select_bit = i[3] & i[2];
      lat = i[3] ? 3 : 2;
      len = 1 << (i % 4);
      r = rnd();
      i_ctrl.mask_level = 2'((i + i / 8) % 4);
      oe_exp = {{8{~i_ctrl.mask_level[1]}}, {8{~i_ctrl.mask_level[0]}}};
      i_ctrl.drive(PRE, 2'(rnd()), 13'(rnd()) | 13'h0400, 16'(rnd()),
        1);
      i_ctrl.load_cfg(cfg);
      activate(r[1:0], r[14:2]);
      access(1'h0, r[1:0], i[3] ? r[25:16] : {r[25:19], 3'h5}, 1'h0, len,
        i[2], 0);
      access(1'h1, r[1:0], r[31:22], i[1],
        cfg.single_write_select_bit ? 1 : len, i[2], 0);
      check_word({15'h0000, bank_open[r[1:0]]},
        i[1] ? 16'h0000 : 16'h0001);
    end
    i_ctrl.mask_level = 2'h0;
    oe_exp = 16'hFFFF;
    lat = 2;
    cfg = '0;
    cfg.burst_length_setting = sdram_cmd_pkg::LEN_FULL;
    cfg.burst_order_select_bit = 1'h1;
    cfg.read_latency_setting = sdram_cmd_pkg::LAT_2;
    i_ctrl.drive(PRE, 2'(rnd()), 13'(rnd()) | 13'h0400, 16'(rnd()), 1);
    i_ctrl.load_cfg(cfg);
    for (int b = 0; b < 4; b++)
      activate(2'(b), 13'(rnd()));
    access(1'h0, 2'h3, 10'h3FD, 1'h0, 1024, 1'h0, 6);
    i_ctrl.drive(PRE, 2'h2, 13'h0000, 16'h0000, 1);
    i_ctrl.idle(3);
    check_word({12'h000, bank_open}, 16'h000B);
    i_ctrl.drive(PRE, 2'(rnd()), 13'(rnd()) | 13'h0400, 16'(rnd()), 1);
    i_ctrl.idle(3);
    check_word({12'h000, bank_open}, 16'h0000);
    i_ctrl.drive(REF, 2'(rnd()), 13'(rnd()), 16'(rnd()), 1);
    i_ctrl.idle(4);
    check_word(16'(refreshes), 16'h0001);
    i_ctrl.cke_level = 1'h0;
    i_ctrl.drive(REF, 2'(rnd()), 13'(rnd()), 16'(rnd()), 1);
    i_ctrl.idle(4);
    check_word({15'h0000, self_refresh}, 16'h0001);
    i_ctrl.cke_level = 1'h1;
    i_ctrl.idle(4);
    check_word({15'h0000, self_refresh}, 16'h0000);
    check_word(16'(refreshes), 16'h0001);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
